// ### core/dao_consts.vh
// Constants for the dual converter output and power-mode block
`ifndef DAO_CONSTS_VH
`define DAO_CONSTS_VH

// =====================================================================
// Data format
`define DAO_CODE_WIDTH 8
`define DAO_OFFSET_FLIP 8'h80
`define DAO_BUS_RESET 8'h00

// =====================================================================
// Power modes, first select pin is the upper bit of the pair
`define DAO_MODE_SHUTDOWN 2'h0
`define DAO_MODE_STANDBY 2'h1
`define DAO_MODE_IDLE 2'h2
`define DAO_MODE_NORMAL 2'h3

// =====================================================================
// Pipeline delay in conversion-clock cycles and FIFO depth in entries
`define DAO_PIPE_STAGES 5
`define DAO_FIFO_DEPTH 16

`endif

// ### core/dao_fifo.v
// Synchronous FIFO with valid/ready on both sides and a fill level
`timescale 1ns/1ps
`default_nettype none

module dao_fifo
#(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    // Clock and synchronous reset
    input wire clk,
    input wire rst_n,
    // Filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    // Number of words held
    output wire [AW:0] level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_push;
    wire do_pop;

    // =================================================================
    // Handshake terms; a full FIFO still accepts when it pops the same cycle
    assign do_pop = out_valid & out_ready;
    assign do_push = in_valid & in_ready;
    assign in_ready = (count != DEPTH[AW:0]) | out_ready;
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign level = count;

    // Storage has no reset; only the pointers and fill count define what is valid
    always @(posedge clk)
    begin
        if (do_push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers and fill count
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (do_push & ~do_pop)
                count <= count + 1'b1;
            else if (do_pop & ~do_push)
                count <= count - 1'b1;
        end
    end

endmodule

`default_nettype wire

// ### core/dao_output_mux.v
// Output multiplexer, offset-binary coding and power-mode control
// Operation
// - Results are 8-bit offset binary, MSB highest.
// - Zero gives 80, top FF, bottom 00.
// - Two select pins choose four power modes.
// - Shutdown: everything off, outputs high-impedance.
// - Standby: reference and clock on, outputs off.
// - Idle: converters on, bus and indicator released.
// - Normal: all powered, bus and indicator driven.
// - Re-enabled outputs first show the last word.
// - Both channels sampled on conversion clock rise.
// - First word on rise, second on fall.
// - Indicator high for first, low for second.
// - Latency five cycles first, five and half second.
`timescale 1ns/1ps
`default_nettype none
`include "dao_consts.vh"

module dao_output_mux
#(
    parameter CODE_WIDTH = `DAO_CODE_WIDTH,
    parameter PIPE_STAGES = `DAO_PIPE_STAGES,
    parameter FIFO_DEPTH = `DAO_FIFO_DEPTH
)
(
    // System clock and synchronous reset
    input wire MCLK,
    input wire RESETN,
    // Conversion clock pin, sampled as an ordinary input
    input wire CONVERSION_CLOCK,
    // Power mode select pins
    input wire POWER_SELECT_FIRST,
    input wire POWER_SELECT_SECOND,
    // Two's complement codes from the converter core, same clock domain
    input wire [CODE_WIDTH-1:0] FIRST_CHANNEL_CODE,
    input wire [CODE_WIDTH-1:0] SECOND_CHANNEL_CODE,
    // Result bus pins, enable active low
    output reg [CODE_WIDTH-1:0] CONVERSION_RESULT_BUS_O,
    output reg CONVERSION_RESULT_BUS_OE_N,
    // Channel indicator pin, enable active low
    output reg FIRST_CHANNEL_O,
    output reg FIRST_CHANNEL_OE_N,
    // Power switch controls for the analog sections
    output reg CONVERTER_POWER,
    output reg REFERENCE_POWER,
    output reg CLOCK_DIST_POWER
);

    localparam AW = 4;
    localparam PAIR_WIDTH = 2 * CODE_WIDTH;

    reg [1:0] conv_clk_sync;
    reg conv_clk_prev;
    reg [1:0] sel_first_sync;
    reg [1:0] sel_second_sync;
    reg [1:0] mode;
    reg [CODE_WIDTH-1:0] second_hold;
    reg second_pending;
    reg [CODE_WIDTH-1:0] last_word;
    wire conv_rise;
    wire conv_fall;
    wire [1:0] next_mode;
    wire converting;
    wire clocks_on;
    wire outputs_on;
    wire [CODE_WIDTH-1:0] first_offset;
    wire [CODE_WIDTH-1:0] second_offset;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [PAIR_WIDTH-1:0] fifo_out_data;
    wire [AW:0] fifo_level;

    // =================================================================
    // Pin synchronisers
    // The conversion clock and both select pins pass two flops; the first stage feeds only the second
    always @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            conv_clk_sync <= 2'h0;
            conv_clk_prev <= 1'b0;
            sel_first_sync <= 2'h0;
            sel_second_sync <= 2'h0;
        end
        else
        begin
            conv_clk_sync <= {conv_clk_sync[0], CONVERSION_CLOCK};
            conv_clk_prev <= conv_clk_sync[1];
            sel_first_sync <= {sel_first_sync[0], POWER_SELECT_FIRST};
            sel_second_sync <= {sel_second_sync[0], POWER_SELECT_SECOND};
        end
    end

    // Edge events of the conversion clock, one MCLK cycle each
    assign conv_rise = conv_clk_sync[1] & ~conv_clk_prev;
    assign conv_fall = ~conv_clk_sync[1] & conv_clk_prev;

    // =================================================================
    // Power mode decode
    // First select pin is the upper bit, second the lower
    assign next_mode = {sel_first_sync[1], sel_second_sync[1]};

    // Registered mode, shutdown out of reset so nothing is driven early
    always @(posedge MCLK)
    begin
        if (!RESETN)
            mode <= `DAO_MODE_SHUTDOWN;
        else
            mode <= next_mode;
    end

    // Section power per mode
    always @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            CONVERTER_POWER <= 1'b0;
            REFERENCE_POWER <= 1'b0;
            CLOCK_DIST_POWER <= 1'b0;
        end
        else
        begin
            case (mode)
                `DAO_MODE_SHUTDOWN:
                begin
                    CONVERTER_POWER <= 1'b0;
                    REFERENCE_POWER <= 1'b0;
                    CLOCK_DIST_POWER <= 1'b0;
                end
                `DAO_MODE_STANDBY:
                begin
                    CONVERTER_POWER <= 1'b0;
                    REFERENCE_POWER <= 1'b1;
                    CLOCK_DIST_POWER <= 1'b1;
                end
                `DAO_MODE_IDLE:
                begin
                    CONVERTER_POWER <= 1'b1;
                    REFERENCE_POWER <= 1'b1;
                    CLOCK_DIST_POWER <= 1'b1;
                end
                default:
                begin
                    CONVERTER_POWER <= 1'b1;
                    REFERENCE_POWER <= 1'b1;
                    CLOCK_DIST_POWER <= 1'b1;
                end
            endcase
        end
    end

    // Pipeline only runs with powered converters; clock events need distribution
    assign converting = (mode == `DAO_MODE_IDLE) | (mode == `DAO_MODE_NORMAL);
    assign clocks_on = (mode != `DAO_MODE_SHUTDOWN);
    assign outputs_on = (mode == `DAO_MODE_NORMAL);

    // =================================================================
    // Sampling and coding
    // Offset binary is two's complement with the sign bit inverted
    assign first_offset = FIRST_CHANNEL_CODE ^ `DAO_OFFSET_FLIP;
    assign second_offset = SECOND_CHANNEL_CODE ^ `DAO_OFFSET_FLIP;

    // Both channels captured together on the rising event
    assign fifo_in_valid = conv_rise & converting;

    // Drain only once the pipeline is primed, so each pair waits its stages
    assign fifo_out_ready = conv_rise & converting &
                            (fifo_level >= PIPE_STAGES[AW:0]);

    // Delay line; in_ready low drops the captured pair if the drain is ever blocked
    dao_fifo #(
        .WIDTH(PAIR_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(AW)
    ) u_delay (
        .clk(MCLK),
        .rst_n(RESETN),
        .in_valid(fifo_in_valid & fifo_in_ready),
        .in_ready(fifo_in_ready),
        .in_data({first_offset, second_offset}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // =================================================================
    // Output multiplexing
    // First word loads on the rise, its partner waits for the fall.
    // The bus register keeps updating in idle, so it always holds the
    // newest word; enabling the drivers then shows that word first.
    always @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            last_word <= `DAO_BUS_RESET;
            second_hold <= `DAO_BUS_RESET;
            second_pending <= 1'b0;
        end
        else if (fifo_out_ready & fifo_out_valid)
        begin
            last_word <= fifo_out_data[PAIR_WIDTH-1:CODE_WIDTH];
            second_hold <= fifo_out_data[CODE_WIDTH-1:0];
            second_pending <= 1'b1;
        end
        else if (conv_fall & converting & second_pending)
        begin
            last_word <= second_hold;
            second_pending <= 1'b0;
        end
    end

    // Pin registers; last_word leads by one cycle, bus follows it exactly
    always @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            CONVERSION_RESULT_BUS_O <= `DAO_BUS_RESET;
            FIRST_CHANNEL_O <= 1'b0;
        end
        else
        begin
            CONVERSION_RESULT_BUS_O <= last_word;
            if (clocks_on)
                FIRST_CHANNEL_O <= conv_clk_prev;
        end
    end

    // Drivers on only in normal mode; all other modes release both pins
    always @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            CONVERSION_RESULT_BUS_OE_N <= 1'b1;
            FIRST_CHANNEL_OE_N <= 1'b1;
        end
        else
        begin
            CONVERSION_RESULT_BUS_OE_N <= ~outputs_on;
            FIRST_CHANNEL_OE_N <= ~outputs_on;
        end
    end

endmodule

`default_nettype wire

// ### test/dao_output_mux_checker.sv
// Assertion checker for the output multiplexer and power modes
`timescale 1ns/1ps
`default_nettype none

module dao_output_mux_checker
#(
    parameter CODE_WIDTH = 8
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Pins driven by the capture side
    input wire logic CONVERSION_CLOCK,
    input wire logic POWER_SELECT_FIRST,
    input wire logic POWER_SELECT_SECOND,
    // Pins driven by the device
    input wire logic [CODE_WIDTH-1:0] CONVERSION_RESULT_BUS_O,
    input wire logic CONVERSION_RESULT_BUS_OE_N,
    input wire logic FIRST_CHANNEL_O,
    input wire logic FIRST_CHANNEL_OE_N,
    input wire logic CONVERTER_POWER,
    input wire logic REFERENCE_POWER,
    input wire logic CLOCK_DIST_POWER
);
    // =========================================
    // Helpers; six cycles cover sync chain plus mode register
    wire [1:0] sel = {POWER_SELECT_FIRST, POWER_SELECT_SECOND};
    wire [2:0] pwr = {CONVERTER_POWER, REFERENCE_POWER, CLOCK_DIST_POWER};
    wire oe_n = CONVERSION_RESULT_BUS_OE_N;
    wire [CODE_WIDTH-1:0] bus = CONVERSION_RESULT_BUS_O;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    // =========================================
    // Properties
    property p_shut; (sel == 2'h0) [*6] |-> pwr == 3'h0 && oe_n; endproperty
    a_shut: assert property (p_shut) else $error("shutdown state wrong");
    property p_stby; (sel == 2'h1) [*6] |-> pwr == 3'h3 && oe_n; endproperty
    a_stby: assert property (p_stby) else $error("standby state wrong");
    property p_idle; (sel == 2'h2) [*6] |-> pwr == 3'h7 && oe_n; endproperty
    a_idle: assert property (p_idle) else $error("idle state wrong");
    property p_norm; (sel == 2'h3) [*6] |-> pwr == 3'h7 && !oe_n; endproperty
    a_norm: assert property (p_norm) else $error("normal state wrong");
    property p_pair; oe_n == FIRST_CHANNEL_OE_N; endproperty
    a_pair: assert property (p_pair) else $error("enables differ");
    property p_held; !REFERENCE_POWER && !$past(REFERENCE_POWER) |-> $stable(bus); endproperty
    a_held: assert property (p_held) else $error("word lost in shutdown");
    property p_rise; !oe_n && $rose(CONVERSION_CLOCK) |-> ##[1:5] FIRST_CHANNEL_O; endproperty
    a_rise: assert property (p_rise) else $error("indicator not high");
    property p_word; $changed(bus) |-> $changed(FIRST_CHANNEL_O); endproperty
    a_word: assert property (p_word) else $error("word without indicator");
    c_wake: cover property (oe_n ##1 !oe_n);
    c_flow: cover property (!oe_n && $changed(bus));
    c_off: cover property (pwr == 3'h0 ##1 pwr != 3'h0);
endmodule

bind dao_output_mux dao_output_mux_checker #(.CODE_WIDTH(CODE_WIDTH)) u_chk (.MCLK(MCLK), .RESETN(RESETN),
    .CONVERSION_CLOCK(CONVERSION_CLOCK), .POWER_SELECT_FIRST(POWER_SELECT_FIRST),
    .POWER_SELECT_SECOND(POWER_SELECT_SECOND), .CONVERSION_RESULT_BUS_O(CONVERSION_RESULT_BUS_O),
    .CONVERSION_RESULT_BUS_OE_N(CONVERSION_RESULT_BUS_OE_N), .FIRST_CHANNEL_O(FIRST_CHANNEL_O),
    .FIRST_CHANNEL_OE_N(FIRST_CHANNEL_OE_N), .CONVERTER_POWER(CONVERTER_POWER),
    .REFERENCE_POWER(REFERENCE_POWER), .CLOCK_DIST_POWER(CLOCK_DIST_POWER));
`default_nettype wire

// ### test/dao_capture_model.sv
// Capture logic model latching multiplexed words from the bus
`timescale 1ns/1ps
`default_nettype none

module dao_capture_model
#(
    parameter SKIP = 10
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus from the device
    input wire logic [7:0] bus,
    input wire logic bus_oe_n,
    input wire logic ind,
    // Captured word, indicator on top
    output logic cap_valid,
    output logic [8:0] cap_word
);
    logic prev;
    logic [4:0] skip;

    // Latch on each indicator edge while driven; fill words are dropped
    always @(posedge clk)
    begin
        cap_valid <= 1'b0;
        prev <= ind;
        if (!rst_n)
            skip <= SKIP[4:0];
        else if (!bus_oe_n && ind !== prev)
        begin
            if (skip != 5'h0)
                skip <= skip - 5'h1;
            else
                cap_valid <= 1'b1;
            cap_word <= {ind, bus};
        end
    end
endmodule
`default_nettype wire

// ### test/dao_output_mux_tb_top.sv
// Self-checking bench for the output multiplexer and power modes
`timescale 1ns/1ps
`default_nettype none

module dao_output_mux_tb_top;
    `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
    logic mclk = 0, resetn = 0, conv = 0, psf = 0, pss = 0;
    logic [7:0] code_a = 0, code_b = 0, bus;
    logic bus_oe_n, ind, ind_oe_n, p_conv, p_ref, p_clk, cap_valid;
    logic [8:0] cap_word, last_exp;
    logic [8:0] expq[$];
    int n_fail = 0, total_checks = 0;
    // Host wake waits in MCLK cycles of 5 ns; outside driver settling is a free choice
    localparam int REF_UNBUFFERED = 0;
    localparam int EXT_REF_SETTLE = 6000;
    localparam int WAKE_SHUT = REF_UNBUFFERED ? EXT_REF_SETTLE : 4000;
    localparam int WAKE_STBY = 520;
    localparam int WAKE_IDLE = 1;
    logic [1:0] cur_mode = 2'h0;

    // =========================================
    // Clock, device and capture model
    initial forever #2.5 mclk = ~mclk;
    dao_output_mux uut (.MCLK(mclk), .RESETN(resetn), .CONVERSION_CLOCK(conv), .POWER_SELECT_FIRST(psf),
        .POWER_SELECT_SECOND(pss), .FIRST_CHANNEL_CODE(code_a), .SECOND_CHANNEL_CODE(code_b),
        .CONVERSION_RESULT_BUS_O(bus), .CONVERSION_RESULT_BUS_OE_N(bus_oe_n), .FIRST_CHANNEL_O(ind),
        .FIRST_CHANNEL_OE_N(ind_oe_n), .CONVERTER_POWER(p_conv), .REFERENCE_POWER(p_ref),
        .CLOCK_DIST_POWER(p_clk));
    dao_capture_model cap (.clk(mclk), .rst_n(resetn), .bus(bus), .bus_oe_n(bus_oe_n), .ind(ind),
        .cap_valid(cap_valid), .cap_word(cap_word));

    // =========================================
    // Tasks; pins settle in four edges, six leaves margin
    task automatic set_mode(input logic [1:0] m);
        int wake;
        wake = (cur_mode == 2'h0) ? WAKE_SHUT : (cur_mode == 2'h1) ? WAKE_STBY : WAKE_IDLE;
        @(negedge mclk);
        {psf, pss} = m;
        repeat (6) @(negedge mclk);
        // Words are only trusted once the wake wait of the mode left behind has run
        if (m == 2'h3)
            repeat (wake) @(negedge mclk);
        cur_mode = m;
    endtask
    // Codes held over the whole period so the rise event sees them
    task automatic conv_cycle(input logic [7:0] a, input logic [7:0] b);
        @(negedge mclk);
        code_a = a;
        code_b = b;
        conv = 1;
        expq.push_back({1'b1, a ^ 8'h80});
        expq.push_back({1'b0, b ^ 8'h80});
        repeat (8) @(negedge mclk);
        conv = 0;
        repeat (7) @(negedge mclk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Oldest note against each captured word
    always @(posedge mclk)
        if (cap_valid)
        begin
            last_exp = expq.pop_front();
            `CHK(cap_word, last_exp)
        end

    // =========================================
    // Main sequence
    initial
    begin
        bit [2:0] pw[4] = '{3'h0, 3'h3, 3'h7, 3'h7};
        void'($urandom(32'h1CFE));
        repeat (12) @(negedge mclk);
        resetn = 1;
        for (int i = 0; i < 4; i++)
        begin
            set_mode(i[1:0]);
            `CHK({p_conv, p_ref, p_clk}, pw[i])
            `CHK({bus_oe_n, ind_oe_n}, {2{i != 3}})
        end
        conv_cycle(8'h00, 8'h7F);
        conv_cycle(8'h80, 8'h01);
        repeat (12) conv_cycle(8'($urandom), 8'($urandom));
        // Sleep with the clock stopped, then wake on the held word
        set_mode(2'h0);
        `CHK(bus_oe_n, 1'b1)
        set_mode(2'h3);
        `CHK(bus, last_exp[7:0])
        `CHK(bus_oe_n, 1'b0)
        repeat (6) conv_cycle(8'($urandom), 8'($urandom));
        `CHK(expq.size(), 2 * 5)
        end_sim;
    end

    // Watchdog, run needs about 22 us, most of it the shutdown wake wait
    initial
    begin
        #100000;
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
